// ==== rtl/rbc_pkg.sv ====
// Shared constants and types for the reset, boot and clock controller.
package rbc_pkg;

  // Clock rates and the divider ratios derived from them.
  localparam int CLK_HZ      = 50_000_000;
  localparam int INS_HZ      = 1_000_000;
  localparam int INS_DIV     = CLK_HZ / INS_HZ;
  localparam int ANA_HZ      = 70_000;
  localparam int ANA_DIV     = CLK_HZ / ANA_HZ;

  // Oscillator restart delay after brownout recovery, in microseconds.
  localparam int RESTART_US  = 100;
  localparam int RESTART_CYC = RESTART_US * (CLK_HZ / 1_000_000);

  // Cycles the core stays in reset after a one-shot reset source.
  localparam logic [3:0] RESET_HOLD_CYC = 4'h4;

  // Boot entry and password location in program memory.
  localparam logic [15:0] ROM_BASE  = 16'h8000;
  localparam logic [15:0] PW_FIRST  = 16'h0010;
  localparam logic [15:0] PW_LAST   = 16'h001f;
  localparam int          PW_WORDS  = 16;
  localparam logic [15:0] PW_ERASED = 16'hffff;

  // Stack pointer value after reset.
  localparam logic [3:0] SP_RESET = 4'hf;

  // Register byte offsets and the PADDR[7:6] select of the password window.
  localparam logic [7:0] OFF_SYSCTL  = 8'h00;
  localparam logic [7:0] OFF_WDCTL   = 8'h04;
  localparam logic [7:0] OFF_CLKCTL  = 8'h08;
  localparam logic [7:0] OFF_STACK   = 8'h0c;
  localparam logic [1:0] PW_WIN_SEL  = 2'h1;

  // Field positions.
  localparam int SYS_SPE_BIT     = 0;
  localparam int SYS_LOCK_BIT    = 1;
  localparam int SYS_LOADER_BIT  = 5;
  localparam int SYS_DEFINED_BIT = 6;
  localparam int SYS_GRANT_BIT   = 7;
  localparam int WD_EWT_BIT      = 1;
  localparam int WD_WATCHDOG_RESET_FLAG_BIT     = 2;
  localparam int WD_WATCHDOG_INTERRUPT_ENABLE_BIT     = 6;
  localparam int WD_POR_BIT      = 7;
  localparam int CK_TIMER_COUNT_MODE_LSB     = 0;
  localparam int CK_COULOMB_COUNTER_RUN_BIT     = 2;
  localparam int CK_INS_BIT      = 4;
  localparam int CK_ANA_BIT      = 5;

  // Instruction oscillator states, Gray coded along run, brownout, wait.
  typedef enum logic [1:0] {
    OSC_RUN   = 2'b00,
    OSC_BROWN = 2'b01,
    OSC_WAIT  = 2'b11,
    OSC_STOP  = 2'b10
  } rbc_osc_t;

endpackage

// ==== rtl/rbc_sync.sv ====
// Two flip-flop synchroniser for asynchronous pin levels.
`timescale 1ns/10ps
module rbc_sync #(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rst,
  // Asynchronous input and synchronised output.
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  if (W < 1) begin : g_bad_width
    $error("rbc_sync width must be at least one");
  end

  // The first stage feeds only the second stage.
  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= RST_VAL;
      q    <= RST_VAL;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

// ==== rtl/rbc_divider.sv ====
// Cycle counter that emits a one-cycle tick every N enabled cycles.
`timescale 1ns/10ps
module rbc_divider #(
  parameter int N = 2
) (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  // Count enable; low restarts the count.
  input  wire logic en,
  // Registered tick.
  output logic      tick
);

  localparam int W = (N > 1) ? $clog2(N) : 1;

  logic [W-1:0] cnt;
  wire          last = (cnt == W'(N - 1));

  if (N < 1) begin : g_bad_n
    $error("rbc_divider ratio must be at least one");
  end

  // Count while enabled and flag the last cycle of each period.
  always_ff @(posedge clk) begin
    if (rst || !en) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else begin
      tick <= last;
      cnt  <= last ? '0 : cnt + 1'b1;
    end
  end

endmodule

// ==== rtl/rbc_reset_boot_ctrl.sv ====
// Reset, boot entry, password lock and system clock control with APB.
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
module rbc_reset_boot_ctrl
  import rbc_pkg::*;
#(
  parameter int RESTART_CYCLES = RESTART_CYC
) (
  // Clock and synchronous reset.
  input  wire logic        CLK,
  input  wire logic        RST,
  // APB slave.
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Asynchronous pins and supply comparators.
  input  wire logic        EXT_RESET_N,
  input  wire logic        SUPPLY_ABOVE_POR,
  input  wire logic        SUPPLY_ABOVE_BO,
  // Core and loader events on this clock.
  input  wire logic        WDT_TIMEOUT,
  input  wire logic        SYS_INTERRUPT,
  input  wire logic        STOP_EXEC,
  input  wire logic        STACK_PUSH,
  input  wire logic        STACK_POP,
  input  wire logic        JTAG_SPE_SET,
  input  wire logic        SERIAL_PROG_REQ,
  input  wire logic        PW_MATCH,
  input  wire logic        LOADER_EXIT,
  input  wire logic        MASS_ERASE,
  // Reset and boot outputs.
  output logic             CORE_RESET,
  output logic      [15:0] FETCH_START,
  output logic             LOADER_MODE,
  output logic             LOADER_GRANT,
  output logic             MEM_READ_BLOCK,
  output logic      [3:0]  STACK_PTR,
  // Clock control outputs.
  output logic             INS_OSC_EN,
  output logic             ANA_OSC_EN,
  output logic             INS_SLAVED,
  output logic             INS_TICK,
  output logic             ANA_TICK
);

  if (RESTART_CYCLES < 1) begin : g_bad_restart
    $error("restart delay must be at least one cycle");
  end

  logic                      ext_n_s;
  logic                      por_s;
  logic                      bo_s;
  logic                      por_d;
  logic [3:0]                hold_cnt;
  logic                      system_programming_enable;
  logic                      loader_serial;
  logic                      matched;
  logic                      lock;
  logic                      watchdog_interrupt_enable;
  logic                      watchdog_reset_enable;
  logic [1:0]                timer_count_mode;
  logic                      coulomb_counter_run;
  logic                      por_flag;
  logic                      watchdog_reset_flag;
  logic [PW_WORDS*16-1:0]    pw_flat;
  logic                      restart_done;
  logic                      ins_tick_raw;
  logic                      ana_tick_raw;
  rbc_osc_t                  osc_state;
  rbc_osc_t                  next_osc;

  // External reset and supply comparators are synchronised.
  rbc_sync #(
    .W       (3),
    .RST_VAL (3'b001)
  ) u_sync (
    .clk (CLK),
    .rst (RST),
    .d   ({SUPPLY_ABOVE_BO, SUPPLY_ABOVE_POR, EXT_RESET_N}),
    .q   ({bo_s, por_s, ext_n_s})
  );

  // Reset sources and the hold counter that stretches one-shot sources.
  wire       por_rise   = por_s & ~por_d;
  wire       sreset     = RST | por_rise;
  wire       exit_reset = LOADER_EXIT & LOADER_MODE;
  wire       reset_req  = ~por_s | por_rise | ~ext_n_s | WDT_TIMEOUT
                          | exit_reset;
  wire [3:0] next_hold  = reset_req ? RESET_HOLD_CYC :
                          (hold_cnt != 4'h0) ? hold_cnt - 4'h1 : 4'h0;
  wire       reset_fell = CORE_RESET & (next_hold == 4'h0);

  // APB decode and selection.
  wire        apb_acc   = PSEL & PENABLE;
  wire        apb_wr    = apb_acc & PREADY & PWRITE;
  wire        sel_sys   = (PADDR == OFF_SYSCTL);
  wire        sel_wd    = (PADDR == OFF_WDCTL);
  wire        sel_ck    = (PADDR == OFF_CLKCTL);
  wire        sel_sp    = (PADDR == OFF_STACK);
  wire [15:0] pw_prog   = PW_FIRST + {12'h000, PADDR[5:2]};
  wire        sel_pw    = (PADDR[7:6] == PW_WIN_SEL) & (PADDR[1:0] == 2'h0)
                          & (pw_prog <= PW_LAST);
  wire        addr_hit  = sel_sys | sel_wd | sel_ck | sel_sp | sel_pw;
  wire        wd_clr_por  = apb_wr & sel_wd & PWDATA[WD_POR_BIT];
  wire        wd_clr_watchdog_reset_flag = apb_wr & sel_wd & PWDATA[WD_WATCHDOG_RESET_FLAG_BIT];

  // Password is defined unless all zeros or all ones.
  wire pw_defined = (|pw_flat) & ~(&pw_flat);
  // Grant for JTAG loader, or serial loader once lock is satisfied.
  wire next_grant = LOADER_MODE & ~CORE_RESET
                    & (~loader_serial | ~lock | matched);
  // Reads are blocked while a defined password is locked.
  wire next_block = lock & pw_defined & ~matched;
  // Analog oscillator runs on any of its enables.
  wire next_ana   = watchdog_interrupt_enable | watchdog_reset_enable | (timer_count_mode != 2'h0) | coulomb_counter_run;

  // Register read data.
  wire [7:0] sys_rd = {next_grant, pw_defined, LOADER_MODE, 3'h0,
                       lock, system_programming_enable};
  wire [7:0] wd_rd  = {por_flag, watchdog_interrupt_enable, 3'h0, watchdog_reset_flag, watchdog_reset_enable, 1'b0};
  wire [7:0] ck_rd  = {2'h0, ANA_OSC_EN, INS_OSC_EN, 1'b0, coulomb_counter_run, timer_count_mode};
  wire [31:0] rd_data =
    sel_sys ? {24'h0, sys_rd} :
    sel_wd  ? {24'h0, wd_rd} :
    sel_ck  ? {24'h0, ck_rd} :
    sel_sp  ? {28'h0, STACK_PTR} :
    sel_pw  ? {16'h0, pw_flat[PADDR[5:2]*16 +: 16]} : 32'h0;

  // APB answers one cycle into the access phase.
  always_ff @(posedge CLK) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= apb_acc & ~PREADY;
      PRDATA  <= (apb_acc & ~PREADY & ~PWRITE) ? rd_data : 32'h0;
      PSLVERR <= apb_acc & ~PREADY & ~addr_hit;
    end
  end

  // Reset hold counter; the core starts from ROM on release.
  always_ff @(posedge CLK) begin
    if (RST) begin
      por_d       <= 1'b0;
      hold_cnt    <= RESET_HOLD_CYC;
      CORE_RESET  <= 1'b1;
      FETCH_START <= ROM_BASE;
    end else begin
      por_d       <= por_s;
      hold_cnt    <= next_hold;
      CORE_RESET  <= (next_hold != 4'h0);
      FETCH_START <= ROM_BASE;
    end
  end

  // Control bits written by software; power-on resets them all.
  always_ff @(posedge CLK) begin
    if (sreset) begin
      lock <= 1'b1;
      watchdog_interrupt_enable <= 1'b0;
      watchdog_reset_enable  <= 1'b0;
      timer_count_mode <= 2'h0;
      coulomb_counter_run <= 1'b0;
    end else begin
      if (apb_wr && sel_sys) begin
        lock <= PWDATA[SYS_LOCK_BIT];
      end
      if (apb_wr && sel_wd) begin
        watchdog_interrupt_enable <= PWDATA[WD_WATCHDOG_INTERRUPT_ENABLE_BIT];
        watchdog_reset_enable  <= PWDATA[WD_EWT_BIT];
      end
      if (apb_wr && sel_ck) begin
        timer_count_mode <= PWDATA[CK_TIMER_COUNT_MODE_LSB +: 2];
        coulomb_counter_run <= PWDATA[CK_COULOMB_COUNTER_RUN_BIT];
      end
    end
  end

  // Reset cause flags; a new event wins over a software clear.
  always_ff @(posedge CLK) begin
    if (sreset) begin
      por_flag <= 1'b1;
      watchdog_reset_flag     <= 1'b0;
    end else begin
      por_flag <= por_flag & ~wd_clr_por;
      watchdog_reset_flag     <= WDT_TIMEOUT | (watchdog_reset_flag & ~wd_clr_watchdog_reset_flag);
    end
  end

  // Loader entry and exit.
  always_ff @(posedge CLK) begin
    if (sreset) begin
      system_programming_enable           <= 1'b0;
      LOADER_MODE   <= 1'b0;
      loader_serial <= 1'b0;
      matched       <= 1'b0;
    end else if (exit_reset) begin
      system_programming_enable           <= 1'b0;
      LOADER_MODE   <= 1'b0;
      loader_serial <= 1'b0;
      matched       <= 1'b0;
    end else begin
      if (JTAG_SPE_SET && CORE_RESET) begin
        system_programming_enable <= 1'b1;
      end
      if (reset_fell && system_programming_enable) begin
        LOADER_MODE <= 1'b1;
      end else if (SERIAL_PROG_REQ && !CORE_RESET && !LOADER_MODE) begin
        LOADER_MODE   <= 1'b1;
        loader_serial <= 1'b1;
      end
      if (CORE_RESET) begin
        matched <= 1'b0;
      end else if (PW_MATCH && LOADER_MODE) begin
        matched <= 1'b1;
      end
    end
  end

  // Registered loader and lock status outputs.
  always_ff @(posedge CLK) begin
    if (RST) begin
      LOADER_GRANT   <= 1'b0;
      MEM_READ_BLOCK <= 1'b0;
    end else begin
      LOADER_GRANT   <= next_grant;
      MEM_READ_BLOCK <= next_block;
    end
  end

  // Password words; mass erase writes all ones.
  for (genvar i = 0; i < PW_WORDS; i++) begin : g_pw
    always_ff @(posedge CLK) begin
      if (RST || MASS_ERASE) begin
        pw_flat[i*16 +: 16] <= PW_ERASED;
      end else if (apb_wr && sel_pw && PADDR[5:2] == 4'(i)) begin
        pw_flat[i*16 +: 16] <= PWDATA[15:0];
      end
    end
  end

  // Stack pointer: push pre-increments, pop post-decrements.
  always_ff @(posedge CLK) begin
    if (sreset || CORE_RESET) begin
      STACK_PTR <= SP_RESET;
    end else if (STACK_PUSH && !STACK_POP) begin
      STACK_PTR <= STACK_PTR + 4'h1;
    end else if (STACK_POP && !STACK_PUSH) begin
      STACK_PTR <= STACK_PTR - 4'h1;
    end
  end

  // Instruction oscillator next state.
  always_comb begin
    next_osc = osc_state;
    unique case (osc_state)
      OSC_RUN: begin
        if (!bo_s) begin
          next_osc = OSC_BROWN;
        end else if (STOP_EXEC && !CORE_RESET) begin
          next_osc = OSC_STOP;
        end
      end
      OSC_STOP: begin
        if (!bo_s) begin
          next_osc = OSC_BROWN;
        end else if (SYS_INTERRUPT || por_rise) begin
          next_osc = OSC_RUN;
        end
      end
      OSC_BROWN: begin
        if (bo_s) begin
          next_osc = OSC_WAIT;
        end
      end
      OSC_WAIT: begin
        if (!bo_s) begin
          next_osc = OSC_BROWN;
        end else if (restart_done) begin
          next_osc = OSC_RUN;
        end
      end
    endcase
  end

  // Oscillator state and enables.
  always_ff @(posedge CLK) begin
    if (RST) begin
      osc_state  <= OSC_BROWN;
      INS_OSC_EN <= 1'b0;
      ANA_OSC_EN <= 1'b0;
      INS_SLAVED <= 1'b0;
    end else begin
      osc_state  <= next_osc;
      INS_OSC_EN <= (next_osc == OSC_RUN);
      ANA_OSC_EN <= next_ana;
      INS_SLAVED <= next_ana & (next_osc == OSC_RUN);
    end
  end

  // Restart delay counts only while waiting after brownout.
  rbc_divider #(
    .N (RESTART_CYCLES)
  ) u_restart (
    .clk  (CLK),
    .rst  (RST),
    .en   (osc_state == OSC_WAIT),
    .tick (restart_done)
  );

  // Instruction clock enable at 1 MHz while its oscillator runs.
  rbc_divider #(
    .N (INS_DIV)
  ) u_ins_div (
    .clk  (CLK),
    .rst  (RST),
    .en   (INS_OSC_EN),
    .tick (ins_tick_raw)
  );

  // Analog clock enable, independent of the instruction clock.
  rbc_divider #(
    .N (ANA_DIV)
  ) u_ana_div (
    .clk  (CLK),
    .rst  (RST),
    .en   (ANA_OSC_EN),
    .tick (ana_tick_raw)
  );

  // Tick outputs, gated by their oscillators.
  always_ff @(posedge CLK) begin
    if (RST) begin
      INS_TICK <= 1'b0;
      ANA_TICK <= 1'b0;
    end else begin
      INS_TICK <= ins_tick_raw & INS_OSC_EN;
      ANA_TICK <= ana_tick_raw & ANA_OSC_EN;
    end
  end

  // Checks on the controller's own behaviour.
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_exit;
    exit_reset;
  endsequence

  sequence s_reset_then_clear;
    CORE_RESET && !LOADER_MODE && !system_programming_enable;
  endsequence

  a_boot_vector: assert property (
    $fell(CORE_RESET) |-> FETCH_START == ROM_BASE)
    else $error("boot does not start at ROM base");
  a_lock_block: assert property (
    (lock && pw_defined && !matched) |=> MEM_READ_BLOCK)
    else $error("locked password did not block reads");
  a_erase_ones: assert property (
    MASS_ERASE |=> (&pw_flat) && !pw_defined)
    else $error("mass erase left password not all ones");
  a_spe_reset: assert property (
    $rose(system_programming_enable) |-> $past(CORE_RESET))
    else $error("programming enable set outside reset");
  a_exit_reset: assert property (
    s_exit |=> s_reset_then_clear)
    else $error("loader exit did not reset and clear");
  a_serial_lock: assert property (
    (loader_serial && lock && !matched) |=> !LOADER_GRANT)
    else $error("serial loader granted without match");
  a_ins_spacing: assert property (
    INS_TICK |=> !INS_TICK [*8])
    else $error("instruction ticks too close");
  a_ana_enable: assert property (
    ANA_OSC_EN == $past(watchdog_interrupt_enable || watchdog_reset_enable || (timer_count_mode != 2'h0) || coulomb_counter_run))
    else $error("analog oscillator enable wrong");
  a_brown_off: assert property (
    (!bo_s || (osc_state == OSC_WAIT && !restart_done)) |=> !INS_OSC_EN ##0
    (osc_state != OSC_RUN || bo_s))
    else $error("instruction oscillator on during brownout");
  a_slaved: assert property (
    (ANA_OSC_EN && INS_OSC_EN) |-> INS_SLAVED)
    else $error("instruction oscillator not slaved");
  a_reset_runs: assert property (
    (CORE_RESET && osc_state == OSC_RUN && bo_s) |=> INS_OSC_EN)
    else $error("instruction oscillator stopped in reset");
  a_por_flag: assert property (
    por_rise |=> por_flag && CORE_RESET)
    else $error("power-on flag not set");
  a_watchdog_reset_flag_set: assert property (
    WDT_TIMEOUT |=> watchdog_reset_flag && CORE_RESET)
    else $error("watchdog reset flag not set");
  a_ext_reset: assert property (
    !ext_n_s |=> CORE_RESET [*2])
    else $error("external reset did not hold core");
  a_sp_reset: assert property (
    $fell(CORE_RESET) |-> STACK_PTR == SP_RESET)
    else $error("stack pointer not at top after reset");

endmodule

// ==== tb/rbc_prog_model.sv ====
// Behavioural programmer on the JTAG and serial loader side.
`timescale 1ns/10ps
module rbc_prog_model (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst,
  // Device state that the programmer watches.
  input  wire logic       core_reset,
  input  wire logic       loader_mode,
  // Bench command: 0 jtag set, 1 serial request, 2 match, 3 exit.
  input  wire logic       go,
  input  wire logic [1:0] cmd,
  // Loader events towards the device.
  output logic            spe_set,
  output logic            prog_req,
  output logic            match,
  output logic            exit_req
);
  logic       pend;
  logic [1:0] op;
  wire logic  ok;

  // A command waits until the device is in a state that accepts it.
  assign ok = (op == 2'h0) ? core_reset :
              (op == 2'h1) ? !core_reset : loader_mode;

  // Each accepted command leaves as a one-cycle pulse.
  always_ff @(posedge clk) begin
    spe_set  <= 1'b0;
    prog_req <= 1'b0;
    match    <= 1'b0;
    exit_req <= 1'b0;
    if (rst) begin
      pend <= 1'b0;
      op   <= 2'h0;
    end else if (go) begin
      pend <= 1'b1;
      op   <= cmd;
    end else if (pend && ok) begin
      pend     <= 1'b0;
      spe_set  <= (op == 2'h0);
      prog_req <= (op == 2'h1);
      match    <= (op == 2'h2);
      exit_req <= (op == 2'h3);
    end
  end
endmodule

// ==== tb/reset_boot_clock_control_test.sv ====
// Self-checking bench for the reset, boot and clock controller.
`timescale 1ns/10ps
module reset_boot_clock_control_test
  import rbc_pkg::*;
;
  localparam int RCYC = 10;
  localparam int CR = 0, LM = 1, GR = 2, MB = 3, IE = 4, AE = 5;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err;
  logic        ext_n = 1'b1;
  logic        por_ok = 1'b1;
  logic        bo_ok = 1'b1;
  logic [5:0]  ev = 6'h00;
  logic        go = 1'b0;
  logic [1:0]  cmd = 2'h0;
  logic        spe_set, prog_req, match, exit_req, core_rst, loader;
  logic        grant, rd_blk, ins_en, ana_en, slaved, ins_tick, ana_tick;
  logic [15:0] fetch;
  logic [3:0]  sp;
  int          n_fail = 0;
  int          n_tests = 0;
  wire  [5:0]  mon = {ana_en, ins_en, rd_blk, grant, loader, core_rst};

  // Free-running 50 MHz clock.
  always #10 clk = ~clk;

  rbc_reset_boot_ctrl #(.RESTART_CYCLES(RCYC)) dut_u (
    .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .EXT_RESET_N(ext_n), .SUPPLY_ABOVE_POR(por_ok),
    .SUPPLY_ABOVE_BO(bo_ok), .WDT_TIMEOUT(ev[0]),
    .SYS_INTERRUPT(ev[1]), .STOP_EXEC(ev[2]), .STACK_PUSH(ev[3]),
    .STACK_POP(ev[4]), .JTAG_SPE_SET(spe_set),
    .SERIAL_PROG_REQ(prog_req), .PW_MATCH(match),
    .LOADER_EXIT(exit_req), .MASS_ERASE(ev[5]),
    .CORE_RESET(core_rst), .FETCH_START(fetch), .LOADER_MODE(loader),
    .LOADER_GRANT(grant), .MEM_READ_BLOCK(rd_blk), .STACK_PTR(sp),
    .INS_OSC_EN(ins_en), .ANA_OSC_EN(ana_en), .INS_SLAVED(slaved),
    .INS_TICK(ins_tick), .ANA_TICK(ana_tick)
  );

  rbc_prog_model prog_u (
    .clk(clk), .rst(rst), .core_reset(core_rst), .loader_mode(loader),
    .go(go), .cmd(cmd), .spe_set(spe_set), .prog_req(prog_req),
    .match(match), .exit_req(exit_req)
  );

  // Prints the counts and the verdict, then stops.
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Compares one value and counts the result.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Waits n edges, then lets that edge's updates land.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Bounded wait for a watched output to reach a level.
  task automatic wait_for(input int s, input logic v, input int lim);
    for (int i = 0; i < lim; i++) begin
      tick(1);
      if (mon[s] === v)
        return;
    end
    chk(mon[s], v);
    finish_test();
  endtask

  // One APB transfer: setup, then access until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (i == 20) begin
      chk(pready, 1'b1);
      finish_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // One-cycle pulses on the core event inputs and programmer commands.
  task automatic pulse(input logic [5:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 6'h00;
    #1;
  endtask

  task automatic send(input logic [1:0] c);
    @(posedge clk);
    cmd <= c;
    go  <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    #1;
  endtask

  // Reset values, boot entry and an unmapped access.
  task automatic t_reset();
    chk(fetch, 16'h8000);
    rdchk(OFF_SYSCTL, 32'h2);
    rdchk(OFF_WDCTL, 32'h80);
    rdchk(OFF_CLKCTL, 32'h10);
    rdchk(OFF_STACK, 32'hf);
    rdchk(8'h40, 32'hffff);
    apb(1'b0, 8'h10, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    $display("test reset done");
  endtask

  // Push wraps the pointer, push with pop holds, pop returns it.
  task automatic t_stack();
    pulse(6'h08);
    chk(sp, 4'h0);
    pulse(6'h18);
    chk(sp, 4'h0);
    pulse(6'h10);
    chk(sp, 4'hf);
    $display("test stack done");
  endtask

  // Defined password with lock, unlock, mass erase, all-zero words.
  task automatic t_password();
    wr(8'h40, 32'h1234);
    wait_for(MB, 1'b1, 5);
    rdchk(OFF_SYSCTL, 32'h42);
    wr(OFF_SYSCTL, 32'h0);
    wait_for(MB, 1'b0, 5);
    wr(OFF_SYSCTL, 32'h2);
    wr(8'h7c, 32'h0);
    rdchk(8'h7c, 32'h0);
    pulse(6'h20);
    wait_for(MB, 1'b0, 5);
    rdchk(8'h40, 32'hffff);
    rdchk(8'h7c, 32'hffff);
    for (int i = 0; i < 16; i++)
      wr(8'h40 + 8'(4 * i), 32'h0);
    rdchk(OFF_SYSCTL, 32'h2);
    chk(rd_blk, 1'b0);
    $display("test password done");
  endtask

  // Serial loader with and without the lock.
  task automatic t_serial();
    send(2'h1);
    wait_for(LM, 1'b1, 10);
    tick(3);
    chk(grant, 1'b0);
    send(2'h2);
    wait_for(GR, 1'b1, 10);
    send(2'h3);
    wait_for(CR, 1'b1, 10);
    chk(loader, 1'b0);
    wait_for(CR, 1'b0, 20);
    wr(OFF_SYSCTL, 32'h0);
    send(2'h1);
    wait_for(GR, 1'b1, 10);
    send(2'h3);
    wait_for(CR, 1'b1, 10);
    wait_for(CR, 1'b0, 20);
    wr(OFF_SYSCTL, 32'h2);
    $display("test serial done");
  endtask

  // External reset pin with JTAG loader entry and exit.
  task automatic t_jtag();
    @(posedge clk);
    ext_n <= 1'b0;
    tick(1);
    chk(core_rst, 1'b0);
    wait_for(CR, 1'b1, 10);
    chk(ins_en, 1'b1);
    chk(fetch, 16'h8000);
    send(2'h0);
    tick(2);
    rdchk(OFF_SYSCTL, 32'h3);
    @(posedge clk);
    ext_n <= 1'b1;
    tick(1);
    chk(core_rst, 1'b1);
    wait_for(LM, 1'b1, 20);
    chk(core_rst, 1'b0);
    send(2'h3);
    wait_for(CR, 1'b1, 10);
    wait_for(CR, 1'b0, 20);
    chk(loader, 1'b0);
    rdchk(OFF_SYSCTL, 32'h2);
    $display("test jtag done");
  endtask

  // Watchdog reset flag and its clearing.
  task automatic t_wdog();
    wr(OFF_WDCTL, 32'h80);
    rdchk(OFF_WDCTL, 32'h0);
    pulse(6'h01);
    chk(core_rst, 1'b1);
    wait_for(CR, 1'b0, 20);
    chk(fetch, 16'h8000);
    rdchk(OFF_WDCTL, 32'h4);
    wr(OFF_WDCTL, 32'h4);
    rdchk(OFF_WDCTL, 32'h0);
    $display("test watchdog done");
  endtask

  // Each analog enable alone, slaving and the analog tick rate.
  task automatic t_analog();
    logic [7:0]  a [4] = '{OFF_WDCTL, OFF_WDCTL, OFF_CLKCTL, OFF_CLKCTL};
    logic [31:0] v [4] = '{32'h40, 32'h2, 32'h1, 32'h4};
    logic [31:0] n;
    chk(slaved, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wr(a[i], v[i]);
      wait_for(AE, 1'b1, 5);
      chk(slaved, 1'b1);
      wr(a[i], 32'h0);
      wait_for(AE, 1'b0, 5);
    end
    wr(OFF_CLKCTL, 32'h2);
    rdchk(OFF_CLKCTL, 32'h32);
    tick(10);
    n = 32'h0;
    repeat (1428) begin
      tick(1);
      n = n + ana_tick;
    end
    chk(n, 32'h2);
    wr(OFF_CLKCTL, 32'h0);
    wait_for(AE, 1'b0, 5);
    $display("test analog done");
  endtask

  // Instruction clock rate, brownout restart, stop and wake.
  task automatic t_osc();
    logic [31:0] n;
    n = 32'h0;
    repeat (1000) begin
      tick(1);
      n = n + ins_tick;
    end
    chk(n, 32'd20);
    @(posedge clk);
    bo_ok <= 1'b0;
    wait_for(IE, 1'b0, 5);
    @(posedge clk);
    bo_ok <= 1'b1;
    tick(RCYC);
    chk(ins_en, 1'b0);
    wait_for(IE, 1'b1, 10);
    pulse(6'h04);
    wait_for(IE, 1'b0, 5);
    tick(5);
    chk(ins_en, 1'b0);
    pulse(6'h02);
    wait_for(IE, 1'b1, 30);
    $display("test oscillator done");
  endtask

  // Power-on reset restores registers, flag and stack pointer.
  task automatic t_por();
    wr(OFF_SYSCTL, 32'h0);
    pulse(6'h08);
    @(posedge clk);
    por_ok <= 1'b0;
    wait_for(CR, 1'b1, 10);
    @(posedge clk);
    por_ok <= 1'b1;
    wait_for(CR, 1'b0, 30);
    chk(sp, 4'hf);
    rdchk(OFF_WDCTL, 32'h80);
    rdchk(OFF_SYSCTL, 32'h2);
    $display("test power-on done");
  endtask

  // Main sequence.
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    wait_for(CR, 1'b0, 50);
    wait_for(IE, 1'b1, 50);
    t_reset();
    t_stack();
    t_password();
    t_serial();
    t_jtag();
    t_wdog();
    t_analog();
    t_osc();
    t_por();
    finish_test();
  end
endmodule
